// >>> hdl/blcr_pkg.sv
`default_nettype none
package blcr_pkg;
    // Register offsets on the device's internal register port
    localparam logic [7:0] OFFICE_DIM_CURRENT_ADDR = 8'h0C;
    localparam logic [7:0] DARK_MAX_CURRENT_ADDR = 8'h0D;
    localparam logic [7:0] DARK_DIM_CURRENT_ADDR = 8'h0E;
    localparam logic [7:0] SINK_FADE_LAW_CONTROL_ADDR = 8'h0F;

    // Field layout
    localparam int CODE_MSB = 6;
    localparam int CODE_W = 7;
    localparam int LAW_MSB = 1;
    localparam int LAW_W = 2;

    // Values after reset
    localparam logic [6:0] CODE_RESET = 7'h00;
    localparam logic [1:0] LAW_RESET = 2'h0;
    localparam logic [7:0] READ_RESET = 8'h00;
    localparam logic [15:0] CURRENT_RESET = 16'h0000;

    // Ambient level encoding of the level select input
    localparam logic [1:0] LEVEL_DAYLIGHT = 2'h0;
    localparam logic [1:0] LEVEL_OFFICE = 2'h1;
    localparam logic [1:0] LEVEL_DARK = 2'h2;

    // Fade law encodings
    localparam logic [1:0] LAW_LINEAR = 2'h0;
    localparam logic [1:0] LAW_SQUARE = 2'h1;
    localparam logic [1:0] LAW_CUBIC10 = 2'h2;
    localparam logic [1:0] LAW_CUBIC11 = 2'h3;

    // Current mapping: full scale in microamps, code range and its square
    localparam int FULL_SCALE_UA = 30000;
    localparam int CODE_FULL = 127;
    localparam int CODE_FULL_SQ = 16129;
endpackage
`default_nettype wire

// >>> hdl/blcr_level_current_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Office dim current register at 0x0C holds a 7-bit code; bit 7 reserved.
// - Each level uses its dim code after dim timeout or while dim-enable is set.
// - Dark maximum current register at 0x0D holds the dark full-brightness 7-bit code.
// - Dark dim current register at 0x0E holds the dark dimmed 7-bit code.
// - Linear law: 0.236 mA per step, 30 mA full; square law also 30 mA full.
// - Sink fade-control register sits at 0x0F with reserved upper bits.
// - Law field bits 1:0: linear, square, and two square nonlinear-step profiles.
// - Both cubic profiles use square-law current; they differ only in step timing.
module blcr_level_current_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port from the serial interface engine
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regHit,
    // Level selection and dimming controls
    input wire logic [1:0] levelSel,
    input wire logic dimTimeout,
    input wire logic dimEnable,
    input wire logic backlightSquareLaw,
    // Codes held by neighbouring registers
    input wire logic [6:0] daylightMaxCode,
    input wire logic [6:0] daylightDimCode,
    input wire logic [6:0] officeMaxCode,
    // Backlight drive
    output logic [6:0] backlightCode,
    output logic [15:0] backlightCurrentUa,
    // Independent sink fade law
    output logic [1:0] sink_fade_law_out,
    output logic sinkSquareDac,
    output logic sinkNonlinearSteps
);

    // Stored codes
    logic [6:0] office_dim_code;
    logic [6:0] dark_max_code;
    logic [6:0] dark_dim_code;
    logic [1:0] sink_fade_law_sel;

    // Next values of the stored codes
    logic [6:0] next_office_dim_code;
    logic [6:0] next_dark_max_code;
    logic [6:0] next_dark_dim_code;
    logic [1:0] next_sink_fade_law_sel;

    // Next values of the read port
    logic [7:0] next_regRdData;
    logic next_regHit;

    // Register writes; only code bits are kept so reserved bits stay zero
    always_comb begin
        // Hold every code unless it is written
        next_office_dim_code = office_dim_code;
        next_dark_max_code = dark_max_code;
        next_dark_dim_code = dark_dim_code;
        next_sink_fade_law_sel = sink_fade_law_sel;

        // A write changes only the register it addresses
        if (regWrEn) begin
            case (regAddr)
                blcr_pkg::OFFICE_DIM_CURRENT_ADDR: begin
                    next_office_dim_code = regWrData[blcr_pkg::CODE_MSB:0];
                end
                blcr_pkg::DARK_MAX_CURRENT_ADDR: begin
                    next_dark_max_code = regWrData[blcr_pkg::CODE_MSB:0];
                end
                blcr_pkg::DARK_DIM_CURRENT_ADDR: begin
                    next_dark_dim_code = regWrData[blcr_pkg::CODE_MSB:0];
                end
                blcr_pkg::SINK_FADE_LAW_CONTROL_ADDR: begin
                    next_sink_fade_law_sel = regWrData[blcr_pkg::LAW_MSB:0];
                end
                default: begin
                    // Offsets held by neighbouring slices are left alone
                end
            endcase
        end
    end

    // Stored codes; a write lands on the edge that takes the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            office_dim_code <= blcr_pkg::CODE_RESET;
            dark_max_code <= blcr_pkg::CODE_RESET;
            dark_dim_code <= blcr_pkg::CODE_RESET;
            sink_fade_law_sel <= blcr_pkg::LAW_RESET;
        end else begin
            office_dim_code <= next_office_dim_code;
            dark_max_code <= next_dark_max_code;
            dark_dim_code <= next_dark_dim_code;
            sink_fade_law_sel <= next_sink_fade_law_sel;
        end
    end

    // Read port; a read together with a write returns the old value
    always_comb begin
        // Read data holds between reads; the hit flag lasts one cycle
        next_regRdData = regRdData;
        next_regHit = 1'b0;

        if (regRdEn) begin
            // Unmapped offsets read zero so a neighbouring slice may own them
            case (regAddr)
                blcr_pkg::OFFICE_DIM_CURRENT_ADDR: begin
                    next_regRdData = {1'b0, office_dim_code};
                    next_regHit = 1'b1;
                end
                blcr_pkg::DARK_MAX_CURRENT_ADDR: begin
                    next_regRdData = {1'b0, dark_max_code};
                    next_regHit = 1'b1;
                end
                blcr_pkg::DARK_DIM_CURRENT_ADDR: begin
                    next_regRdData = {1'b0, dark_dim_code};
                    next_regHit = 1'b1;
                end
                blcr_pkg::SINK_FADE_LAW_CONTROL_ADDR: begin
                    next_regRdData = {6'h00, sink_fade_law_sel};
                    next_regHit = 1'b1;
                end
                default: begin
                    next_regRdData = blcr_pkg::READ_RESET;
                end
            endcase
        end
    end

    // Read port register
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= blcr_pkg::READ_RESET;
            regHit <= 1'b0;
        end else begin
            regRdData <= next_regRdData;
            regHit <= next_regHit;
        end
    end

    // Drive selection
    logic dimActive;
    logic [6:0] next_backlightCode;

    // Square of a 7-bit code fits 14 bits
    logic [13:0] codeSq;

    // Products held at 32 bits so nothing overflows before the divide
    logic [31:0] linearUa;
    logic [31:0] squareUa;
    logic [15:0] next_backlightCurrentUa;

    // Dim code wins whenever a timeout is pending or software forces dimming
    always_comb begin
        // Either source of dimming is enough; neither is latched here
        dimActive = dimTimeout | dimEnable;

        // Level picks the pair of codes, dimming picks one of the pair
        case (levelSel)
            blcr_pkg::LEVEL_DAYLIGHT: begin
                next_backlightCode = dimActive ? daylightDimCode : daylightMaxCode;
            end
            blcr_pkg::LEVEL_OFFICE: begin
                next_backlightCode = dimActive ? office_dim_code : officeMaxCode;
            end
            blcr_pkg::LEVEL_DARK: begin
                next_backlightCode = dimActive ? dark_dim_code : dark_max_code;
            end
            default: begin
                // Unused level encoding holds the previous drive instead of a glitch to zero
                next_backlightCode = backlightCode;
            end
        endcase
    end

    // Current follows the code now on the drive; the estimate lags the code by one cycle
    always_comb begin
        codeSq = 14'(backlightCode) * 14'(backlightCode);
        // Linear law: one step is full scale over the top code
        linearUa = (32'(backlightCode) * 32'(blcr_pkg::FULL_SCALE_UA)) / 32'(blcr_pkg::CODE_FULL);
        // Square law: full scale over the square of the top code
        squareUa = (32'(codeSq) * 32'(blcr_pkg::FULL_SCALE_UA)) / 32'(blcr_pkg::CODE_FULL_SQ);

        // Division truncates; both estimates stay at or under full scale and fit 16 bits
        next_backlightCurrentUa = backlightSquareLaw ? squareUa[15:0] : linearUa[15:0];
    end

    // Drive code register
    always_ff @(posedge clk) begin
        if (rst) begin
            backlightCode <= blcr_pkg::CODE_RESET;
        end else begin
            backlightCode <= next_backlightCode;
        end
    end

    // Current estimate register, one cycle behind the code
    always_ff @(posedge clk) begin
        if (rst) begin
            backlightCurrentUa <= blcr_pkg::CURRENT_RESET;
        end else begin
            backlightCurrentUa <= next_backlightCurrentUa;
        end
    end

    // Sink law decode: every law except linear uses the square DAC
    always_comb begin
        // The law field is passed on as stored for the fade engine
        sink_fade_law_out = sink_fade_law_sel;
        sinkSquareDac = (sink_fade_law_sel != blcr_pkg::LAW_LINEAR);

        // Cubic profiles keep the square DAC; only their fade step timing differs
        sinkNonlinearSteps = (sink_fade_law_sel == blcr_pkg::LAW_CUBIC10) ||
            (sink_fade_law_sel == blcr_pkg::LAW_CUBIC11);
    end

endmodule
`default_nettype wire

// >>> tb/blcr_level_current_regs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module blcr_level_current_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regHit,
    // Drive and law outputs
    input wire logic [1:0] levelSel,
    input wire logic [6:0] backlightCode,
    input wire logic [1:0] sink_fade_law_out,
    input wire logic sinkSquareDac,
    input wire logic sinkNonlinearSteps
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Mapped window is exactly four bytes
    wire mapped = regAddr >= 8'h0C && regAddr <= 8'h0F;
    hit_on_map_a: assert property (regRdEn && mapped |=> regHit) else $error("no hit");
    miss_zero_a: assert property (regRdEn && !mapped |=> !regHit && regRdData == 8'h00)
        else $error("unmapped read");
    code_rsv_a: assert property (regHit |-> !regRdData[7]) else $error("bit 7 set");
    law_rsv_a: assert property (regRdEn && regAddr == 8'h0F |=> regRdData[7:2] == 6'h00)
        else $error("law reserved bits set");
    law_store_a: assert property (regWrEn && regAddr == 8'h0F |=>
        {6'h00, sink_fade_law_out} == ($past(regWrData) & 8'h03)) else $error("law not stored");
    square_dac_a: assert property (sinkSquareDac == (sink_fade_law_out != 2'h0))
        else $error("dac law decode");
    step_kind_a: assert property (sinkNonlinearSteps == sink_fade_law_out[1])
        else $error("step decode");
    wr_rd_a: assert property (regWrEn && regAddr == 8'h0D ##2 regRdEn && regAddr == 8'h0D |=>
        regRdData == ($past(regWrData, 3) & 8'h7F)) else $error("dark max readback");
    hold_code_a: assert property (levelSel == 2'h3 |=> $stable(backlightCode))
        else $error("code moved on hold");
endmodule
`default_nettype wire

// >>> tb/blcr_level_current_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module blcr_level_current_regs_bench;
    logic clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, dimTimeout = 0, dimEnable = 0, backlightSquareLaw = 0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic [1:0] levelSel = 2'h0, sink_fade_law_out;
    logic [6:0] daylightMaxCode = 7'h44, daylightDimCode = 7'h55, officeMaxCode = 7'h66, backlightCode, e;
    logic [15:0] backlightCurrentUa;
    logic regHit, sinkSquareDac, sinkNonlinearSteps;
    int n_fail = 0, checks_done = 0, cyc = 0;
    blcr_level_current_regs dut_u (
        .clk(clk),
        .rst(rst),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdEn(regRdEn),
        .regRdData(regRdData),
        .regHit(regHit),
        .levelSel(levelSel),
        .dimTimeout(dimTimeout),
        .dimEnable(dimEnable),
        .backlightSquareLaw(backlightSquareLaw),
        .daylightMaxCode(daylightMaxCode),
        .daylightDimCode(daylightDimCode),
        .officeMaxCode(officeMaxCode),
        .backlightCode(backlightCode),
        .backlightCurrentUa(backlightCurrentUa),
        .sink_fade_law_out(sink_fade_law_out),
        .sinkSquareDac(sinkSquareDac),
        .sinkNonlinearSteps(sinkNonlinearSteps)
    );
    always #25 clk = ~clk;
    // Cut a hang short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            $display("mismatch at %0t: run timed out", $time);
            give_verdict();
        end
    end
    task give_verdict;
        $display("n_fail=%0d checks_done=%0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] x);
        checks_done++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    // Read strobe is one cycle; data and hit land one edge later
    task rd(input logic [7:0] a, input logic [7:0] x, input logic h);
        @(posedge clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, x);
        chk(regHit, h);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Reset value, then all ones to show reserved bits drop
        for (int a = 12; a < 16; a++) begin
            rd(8'(a), 8'h00, 1'b1);
            wr(8'(a), 8'hFF);
            rd(8'(a), (a == 15) ? 8'h03 : 8'h7F, 1'b1);
        end
        rd(8'h10, 8'h00, 1'b0);
        rd(8'h0B, 8'h00, 1'b0);
        // Every law code, with reserved bits set on purpose
        for (int i = 0; i < 4; i++) begin
            wr(8'h0F, 8'hFC | 8'(i));
            #1;
            chk(16'(sink_fade_law_out), 16'(i));
            chk(sinkSquareDac, i != 0);
            chk(sinkNonlinearSteps, i > 1);
        end
        wr(8'h0C, 8'h11);
        wr(8'h0D, 8'h22);
        wr(8'h0E, 8'h33);
        // Each level with no dim, dim timeout, dim enable
        for (int l = 0; l < 3; l++) begin
            for (int m = 0; m < 3; m++) begin
                @(posedge clk);
                levelSel <= 2'(l);
                dimTimeout <= m == 1;
                dimEnable <= m == 2;
                backlightSquareLaw <= l == 1;
                e = (l == 0) ? (m != 0 ? 7'h55 : 7'h44) : (l == 1) ? (m != 0 ? 7'h11 : 7'h66) : (m != 0 ? 7'h33 : 7'h22);
                @(posedge clk);
                #1;
                chk(backlightCode, e);
                @(posedge clk);
                #1;
                chk(backlightCurrentUa, 16'((l == 1) ? e * e * 30000 / 16129 : e * 30000 / 127));
            end
        end
        // Unused level code keeps the last drive
        @(posedge clk);
        levelSel <= 2'h3;
        dimEnable <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(backlightCode, 7'h33);
        wr(8'h0D, 8'hD5);
        rd(8'h0D, 8'h55, 1'b1);
        give_verdict();
    end
endmodule
bind blcr_level_current_regs blcr_level_current_regs_chk chk_u (
    .clk(clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrEn(regWrEn),
    .regWrData(regWrData),
    .regRdEn(regRdEn),
    .regRdData(regRdData),
    .regHit(regHit),
    .levelSel(levelSel),
    .backlightCode(backlightCode),
    .sink_fade_law_out(sink_fade_law_out),
    .sinkSquareDac(sinkSquareDac),
    .sinkNonlinearSteps(sinkNonlinearSteps)
);
`default_nettype wire
